// File: design/sisr_top.v
// sisr_top.v - system info and scratch register bank on the internal i/o bus
// assumes: a cpu-side i/o bus on clk_i with one-cycle strobes and a registered read answer
// assumes: every input comes from logic on clk_i, so none of them is synchronised here
// assumes: overlapping requests in one cycle are settled by fixed priority, never refused
//
// Summary of operation
// RL1 - A read-only 8-bit silicon revision register sits at byte offset 1 of the config block.
// RL2 - The revision byte comes from a fixed parameter, not a writable flop, from reset on.
// RL3 - Four 8-bit scratch registers exist, every bit read/write and cleared to zero by reset.
// RL4 - Scratch register n sits n bytes above the first and keeps the last byte written to it.
// RL5 - Set-bit, clear-bit and skip-on-bit ops reach one scratch bit and leave the other seven.
// RL6 - Writes to the revision and reserved bytes are ignored, and the reserved byte reads zero.

`timescale 1ns/1ps
`include "sisr_regs.vh"

module sisr_top #(
    // value per silicon step: 0x00 is the first revision; this default is arbitrary
    parameter [7:0] REVISION_CODE = `SISR_REVISION_DEFAULT
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       rstn_i,
    // config block access
    input  wire       cfg_sel_i,
    input  wire       cfg_rd_i,
    input  wire       cfg_wr_i,
    input  wire [3:0] cfg_addr_i,
    input  wire [7:0] cfg_wdata_i,
    // scratch window byte access
    input  wire       scr_sel_i,
    input  wire       scr_rd_i,
    input  wire       scr_wr_i,
    input  wire [1:0] scr_addr_i,
    input  wire [7:0] scr_wdata_i,
    // scratch window bit access
    input  wire       set_single_bit_instr_i,
    input  wire       clear_single_bit_instr_i,
    input  wire       skip_if_bit_set_instr_i,
    input  wire       skip_if_bit_clear_instr_i,
    input  wire [2:0] bit_sel_i,
    // answers
    output reg  [7:0] rdata_o,
    output reg        rvalid_o,
    output reg        skip_o,
    output reg        skip_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // request decode
    // strobes are qualified by their window select once, here, so nothing below can
    // act on a strobe that belongs to the other window

    // byte access
    wire       cfg_rd_req;
    wire       scr_rd_req;
    wire       scr_wr_req;
    // bit access
    wire       bit_set_req;
    wire       bit_clr_req;
    wire       skip_set_req;
    wire       skip_clr_req;
    wire       skip_req;

    // a config read outranks a scratch read in the same cycle
    assign cfg_rd_req   = cfg_sel_i && cfg_rd_i;
    assign scr_rd_req   = scr_sel_i && scr_rd_i && !cfg_rd_req;
    assign scr_wr_req   = scr_sel_i && scr_wr_i;

    assign bit_set_req  = scr_sel_i && set_single_bit_instr_i;   // see RL5
    assign bit_clr_req  = scr_sel_i && clear_single_bit_instr_i; // see RL5

    // a set-skip outranks a clear-skip, so at most one test is ever answered
    assign skip_set_req = scr_sel_i && skip_if_bit_set_instr_i;
    assign skip_clr_req = scr_sel_i && skip_if_bit_clear_instr_i && !skip_set_req;
    assign skip_req     = skip_set_req || skip_clr_req;

    // cfg_wr_i and cfg_wdata_i are deliberately unused: both config bytes ignore writes (see RL6)

    ////////////////////////////////////////////////////////////////////////////
    // scratch index decode; one-hot so each byte sees only its own strobes

    reg  [`SISR_SCRATCH_COUNT-1:0] scr_hit;

    always @* begin
        scr_hit = {`SISR_SCRATCH_COUNT{1'b0}};
        case ({2'b00, scr_addr_i})
            `SISR_SCRATCH_0_OFS: scr_hit = 4'h1; // see RL4
            `SISR_SCRATCH_1_OFS: scr_hit = 4'h2; // see RL4
            `SISR_SCRATCH_2_OFS: scr_hit = 4'h4; // see RL4
            `SISR_SCRATCH_3_OFS: scr_hit = 4'h8; // see RL4
            default:             scr_hit = 4'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // scratch bank

    wire [7:0]                     scratch_byte_n [0:`SISR_SCRATCH_COUNT-1];
    wire [`SISR_SCRATCH_COUNT-1:0] byte_we;
    wire [`SISR_SCRATCH_COUNT-1:0] byte_set;
    wire [`SISR_SCRATCH_COUNT-1:0] byte_clr;

    genvar g;
    generate
        for (g = 0; g < `SISR_SCRATCH_COUNT; g = g + 1) begin : g_scratch
            // a byte write outranks a bit op on the same byte inside the register
            assign byte_we[g]  = scr_hit[g] && scr_wr_req;  // see RL4
            assign byte_set[g] = scr_hit[g] && bit_set_req; // see RL5
            assign byte_clr[g] = scr_hit[g] && bit_clr_req; // see RL5
            sisr_scratch_byte u_byte (
                .clk_i        (clk_i),
                .rstn_i       (rstn_i),
                .byte_we_i    (byte_we[g]),
                .byte_wdata_i (scr_wdata_i),
                .bit_set_i    (byte_set[g]),
                .bit_clr_i    (byte_clr[g]),
                .bit_sel_i    (bit_sel_i),
                .value_o      (scratch_byte_n[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // byte and bit select for reads and skip tests; both see the stored value, so a
    // write in the same cycle shows up only on the next access

    reg  [7:0] sel_byte;
    wire       sel_bit;

    always @* begin
        case ({2'b00, scr_addr_i})
            `SISR_SCRATCH_0_OFS: sel_byte = scratch_byte_n[0];
            `SISR_SCRATCH_1_OFS: sel_byte = scratch_byte_n[1];
            `SISR_SCRATCH_2_OFS: sel_byte = scratch_byte_n[2];
            `SISR_SCRATCH_3_OFS: sel_byte = scratch_byte_n[3];
            default:             sel_byte = 8'h00;
        endcase
    end

    assign sel_bit = sel_byte[bit_sel_i];

    ////////////////////////////////////////////////////////////////////////////
    // config block; the revision byte is a constant so no write path exists for it

    reg [7:0] cfg_byte;

    always @* begin
        case (cfg_addr_i)
            `SISR_CFG_REVISION_OFS: cfg_byte = REVISION_CODE;        // see RL1, RL2
            `SISR_CFG_RESERVED_OFS: cfg_byte = `SISR_RESERVED_VALUE; // see RL6
            default:                cfg_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer one cycle after the taking edge; data rests at zero when idle

    reg [7:0] rdata_next;
    reg       rvalid_next;

    always @* begin
        rdata_next  = 8'h00;
        rvalid_next = 1'b0;
        if (cfg_rd_req) begin
            rvalid_next = 1'b1;
            rdata_next  = cfg_byte;
        end else if (scr_rd_req) begin
            rvalid_next = 1'b1;
            rdata_next  = sel_byte; // see RL3
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // skip test samples the bit before any same-cycle write lands

    reg skip_next;
    reg skip_valid_next;

    always @* begin
        skip_next       = 1'b0;
        skip_valid_next = skip_req;
        if (skip_set_req) begin
            skip_next = sel_bit;  // see RL5
        end else if (skip_clr_req) begin
            skip_next = ~sel_bit; // see RL5
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            skip_o <= 1'b0;
        end else begin
            skip_o <= skip_next;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            skip_valid_o <= 1'b0;
        end else begin
            skip_valid_o <= skip_valid_next;
        end
    end

endmodule // sisr_top

// File: design/sisr_regs.vh
// sisr_regs.vh - offsets, field positions and reset values of the system info / scratch bank
// assumes: included by the design files of the sisr block by bare name
`ifndef SISR_REGS_VH
`define SISR_REGS_VH

// system configuration block, byte offsets
`define SISR_CFG_RESERVED_OFS  4'h0
`define SISR_CFG_REVISION_OFS  4'h1

// scratch window, byte offsets from the first scratch byte
`define SISR_SCRATCH_0_OFS     4'h0
`define SISR_SCRATCH_1_OFS     4'h1
`define SISR_SCRATCH_2_OFS     4'h2
`define SISR_SCRATCH_3_OFS     4'h3
`define SISR_SCRATCH_COUNT     4

// field layout and reset values
`define SISR_BYTE_MSB          7
`define SISR_SCRATCH_RESET     8'h00
`define SISR_RESERVED_VALUE    8'h00
`define SISR_REVISION_DEFAULT  8'h00

`endif

// File: design/sisr_scratch_byte.v
// sisr_scratch_byte.v - one byte-wide read/write scratch register with per-bit access
// assumes: write strobes and bit controls come from logic on the same clock

`timescale 1ns/1ps
`include "sisr_regs.vh"

module sisr_scratch_byte (
    // clock and reset
    input  wire       clk_i,
    input  wire       rstn_i,
    // access controls
    input  wire       byte_we_i,
    input  wire [7:0] byte_wdata_i,
    input  wire       bit_set_i,
    input  wire       bit_clr_i,
    input  wire [2:0] bit_sel_i,
    // stored value
    output wire [7:0] value_o
);

    reg  [7:0] value_reg;
    reg  [7:0] value_next;
    wire [7:0] bit_mask;

    assign bit_mask = 8'h01 << bit_sel_i;
    assign value_o  = value_reg;

    ////////////////////////////////////////////////////////////////////////////
    // single-bit ops touch only the selected bit, the other seven hold (see RL5)
    always @* begin
        value_next = value_reg;
        if (byte_we_i) begin
            value_next = byte_wdata_i; // see RL4
        end else if (bit_set_i) begin
            value_next = value_reg | bit_mask; // see RL5
        end else if (bit_clr_i) begin
            value_next = value_reg & ~bit_mask; // see RL5
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            value_reg <= `SISR_SCRATCH_RESET; // see RL3
        end else begin
            value_reg <= value_next;
        end
    end

endmodule // sisr_scratch_byte

// File: verif/sisr_assertions.sv
// sisr_assertions.sv - port checks of the scratch and revision bank
// assumes: bound to sisr_top, one clock domain
`timescale 1ns/1ps
module sisr_assertions #(parameter [7:0] REVISION_CODE = 8'h00) (
    input logic clk_i, rstn_i, cfg_sel_i, cfg_rd_i, cfg_wr_i, scr_sel_i, scr_rd_i, scr_wr_i,
    input logic set_single_bit_instr_i, clear_single_bit_instr_i, skip_if_bit_set_instr_i,
    input logic skip_if_bit_clear_instr_i, rvalid_o, skip_o, skip_valid_o,
    input logic [3:0] cfg_addr_i,
    input logic [7:0] cfg_wdata_i, scr_wdata_i, rdata_o,
    input logic [1:0] scr_addr_i,
    input logic [2:0] bit_sel_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire cfg_rd = cfg_sel_i && cfg_rd_i;
    wire scr_rd = scr_sel_i && scr_rd_i && !cfg_rd;
    wire sk     = scr_sel_i && (skip_if_bit_set_instr_i || skip_if_bit_clear_instr_i);
    // same byte and bit as the op two cycles back, with an idle cycle between
    logic       sel_d1  = 1'b0;
    logic [1:0] addr_d1 = 2'h0;
    logic [1:0] addr_d2 = 2'h0;
    logic [2:0] bit_d1  = 3'h0;
    logic [2:0] bit_d2  = 3'h0;
    always @(posedge clk_i) begin
        sel_d1  <= scr_sel_i;
        addr_d1 <= scr_addr_i;
        addr_d2 <= addr_d1;
        bit_d1  <= bit_sel_i;
        bit_d2  <= bit_d1;
    end
    wire same   = !sel_d1 && scr_addr_i == addr_d2 && bit_sel_i == bit_d2;
    ////////////////////////////////////////////////////////////////////////////
    a_rev_read: assert property (cfg_rd && cfg_addr_i == 4'h1 |=> rvalid_o
        && rdata_o == REVISION_CODE) else $error("revision read wrong");
    a_resv_zero: assert property (cfg_rd && cfg_addr_i == 4'h0 |=> rvalid_o
        && rdata_o == 8'h00) else $error("reserved byte not zero");
    a_wr_keep: assert property (scr_sel_i && scr_wr_i ##2 scr_rd && same
        |=> rdata_o == $past(scr_wdata_i, 3)) else $error("scratch byte lost");
    a_bit_set: assert property (scr_sel_i && set_single_bit_instr_i && !scr_wr_i
        ##2 sk && skip_if_bit_set_instr_i && same |=> skip_o) else $error("bit not set");
    a_bit_clr: assert property (scr_sel_i && clear_single_bit_instr_i && !scr_wr_i
        && !set_single_bit_instr_i
        ##2 sk && !skip_if_bit_set_instr_i && same |=> skip_o) else $error("bit not clear");
    a_skip_ans: assert property (sk && !cfg_rd && !scr_rd
        |=> skip_valid_o && !rvalid_o) else $error("skip answer missing");
    c_rev: cover property (cfg_rd && cfg_addr_i == 4'h1);
    c_set: cover property (scr_sel_i && set_single_bit_instr_i);
    c_skc: cover property (sk && skip_if_bit_clear_instr_i);
endmodule // sisr_assertions
bind sisr_top sisr_assertions #(.REVISION_CODE(REVISION_CODE)) u_chk (.*);

// File: verif/sisr_cpu_model.sv
// sisr_cpu_model.sv - cpu side of the i/o bus, one request per op call
// assumes: request launched at a falling edge, answer one cycle after the taking edge
`timescale 1ns/1ps
module sisr_cpu_model (
    input  logic clk_i, rvalid_o, skip_o, skip_valid_o,
    input  logic [7:0] rdata_o,
    output logic cfg_sel_i = 0, cfg_rd_i = 0, cfg_wr_i = 0, scr_sel_i = 0, scr_rd_i = 0,
    output logic scr_wr_i = 0, set_single_bit_instr_i = 0, clear_single_bit_instr_i = 0,
    output logic skip_if_bit_set_instr_i = 0, skip_if_bit_clear_instr_i = 0,
    output logic [3:0] cfg_addr_i = 0,
    output logic [7:0] cfg_wdata_i = 0, scr_wdata_i = 0,
    output logic [1:0] scr_addr_i = 0,
    output logic [2:0] bit_sel_i = 0,
    output logic [10:0] ans = 0
);
    // k: 0 cfg rd, 1 cfg wr, 2 wr, 3 rd, 4 set, 5 clr, 6 skip set, 7 skip clr
    task op(input int k, input logic [3:0] a, input logic [7:0] d, input logic [2:0] b);
        @(negedge clk_i);
        {skip_if_bit_clear_instr_i, skip_if_bit_set_instr_i, clear_single_bit_instr_i,
         set_single_bit_instr_i, scr_rd_i, scr_wr_i, cfg_wr_i, cfg_rd_i} = 8'h01 << k;
        cfg_sel_i = k < 2;
        scr_sel_i = k >= 2;
        {cfg_addr_i, scr_addr_i, cfg_wdata_i, scr_wdata_i, bit_sel_i} = {a, a[1:0], d, d, b};
        @(negedge clk_i);
        ans = {rvalid_o, skip_valid_o, skip_o, rdata_o};
        {cfg_rd_i, cfg_wr_i, scr_rd_i, scr_wr_i, cfg_sel_i, scr_sel_i} = 6'h00;
        {set_single_bit_instr_i, clear_single_bit_instr_i} = 2'h0;
        {skip_if_bit_set_instr_i, skip_if_bit_clear_instr_i} = 2'h0;
        // released lines show no stale value
        {cfg_addr_i, scr_addr_i, cfg_wdata_i, scr_wdata_i, bit_sel_i} = ~{a, a[1:0], d, d, b};
    endtask
endmodule // sisr_cpu_model

// File: verif/sisr_top_tb_top.sv
// sisr_top_tb_top.sv - self-checking bench of the scratch and revision bank
// assumes: design files and the cpu model compiled before it
`timescale 1ns/1ps
module sisr_top_tb_top;
    localparam logic [7:0] REV = 8'h3C; // arbitrary revision value
    logic clk_i = 0, rstn_i = 0, rvalid_o, skip_o, skip_valid_o;
    logic [7:0] rdata_o, exp_q [4] = '{default: 8'h00};
    logic [10:0] ans;
    wire cfg_sel_i, cfg_rd_i, cfg_wr_i, scr_sel_i, scr_rd_i, scr_wr_i, set_single_bit_instr_i;
    wire clear_single_bit_instr_i, skip_if_bit_set_instr_i, skip_if_bit_clear_instr_i;
    wire [3:0] cfg_addr_i;
    wire [7:0] cfg_wdata_i, scr_wdata_i;
    wire [1:0] scr_addr_i;
    wire [2:0] bit_sel_i;
    int err_total = 0, cmp_count = 0, cyc = 0, i;
    sisr_top #(.REVISION_CODE(REV)) u_dut (.*);
    sisr_cpu_model u_cpu (.*);
    always #4 clk_i = ~clk_i;
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [10:0] seen, input logic [10:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value answer expected %h seen %h", want, seen);
        end
    endtask
    // answer {rvalid, skip_valid, skip, rdata} that op k must bring back
    function automatic logic [10:0] exp_ans(input int k, input logic [3:0] a,
                                            input logic [2:0] b);
        case (k)
            0: exp_ans = {3'b100, (a == 4'h1) ? REV : 8'h00};
            3: exp_ans = {3'b100, exp_q[a[1:0]]};
            6, 7: exp_ans = {2'b01, exp_q[a[1:0]][b] ^ (k == 7), 8'h00};
            default: exp_ans = 11'h000;
        endcase
    endfunction
    task go(input int k, input logic [3:0] a, input logic [7:0] d, input logic [2:0] b);
        u_cpu.op(k, a, d, b);
        case (k)
            0: chk(ans, exp_ans(k, a, b));
            1: chk(ans, exp_ans(k, a, b));
            3: chk(ans, exp_ans(k, a, b));
            6, 7: chk(ans, exp_ans(k, a, b));
            default: chk(ans, exp_ans(k, a, b));
        endcase
        case (k)
            2: exp_q[a[1:0]] = d;
            4: exp_q[a[1:0]][b] = 1'b1;
            5: exp_q[a[1:0]][b] = 1'b0;
            default: ;
        endcase
    endtask
    always @(posedge clk_i) if (++cyc == 3000) begin err_total++; wrap_up; end
    initial begin
        void'($urandom(40));
        repeat (5) @(posedge clk_i);
        @(negedge clk_i) rstn_i = 1;
        for (i = 0; i < 4; i++) go(3, i, 0, 0);
        go(1, 1, 8'hFF, 0);
        go(1, 0, 8'hFF, 0);
        for (i = 0; i < 16; i++) go(0, i, 0, 0);
        go(2, 3, 8'hA5, 0);
        go(3, 3, 0, 0);
        for (i = 4; i < 8; i++) go(i, 2, 0, 7);
        // set then test-set, clear then test-clear on one bit, an idle cycle apart
        go(4, 1, 0, 3);
        go(6, 1, 0, 3);
        go(5, 1, 0, 3);
        go(7, 1, 0, 3);
        for (i = 0; i < 500; i++) go(2 + $urandom % 6, $urandom % 4, $urandom, $urandom % 8);
        // a second reset mid-run must clear every scratch byte again
        @(negedge clk_i) rstn_i = 0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1;
        exp_q = '{default: 8'h00};
        for (i = 0; i < 4; i++) go(3, i, 0, 0);
        wrap_up;
    end
endmodule // sisr_top_tb_top
